// >>> hdl/rx_byte_fifo.sv
`timescale 1ns/1ps
module rx_byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic flush_i,
  // Fill side
  input wire logic in_valid_i,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic in_ready_o,
  // Drain side
  output logic out_valid_o,
  output logic [WIDTH-1:0] out_data_o,
  input wire logic out_ready_i,
  // Fill level
  output logic [$clog2(DEPTH):0] count_o
);

  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("rx_byte_fifo: DEPTH must be a power of two");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr_reg;
  logic [AW:0] wr_ptr_next;
  logic [AW:0] rd_ptr_reg;
  logic [AW:0] rd_ptr_next;
  logic push;
  logic pop;

  // Handshakes and pointer arithmetic
  always_comb begin
    count_o = wr_ptr_reg - rd_ptr_reg;
    in_ready_o = (count_o != DEPTH[AW:0]);
    out_valid_o = (count_o != '0);
    out_data_o = mem[rd_ptr_reg[AW-1:0]];
    push = in_valid_i && in_ready_o;
    pop = out_valid_o && out_ready_i;
    wr_ptr_next = flush_i ? '0 : wr_ptr_reg + {{AW{1'b0}}, push};
    rd_ptr_next = flush_i ? '0 : rd_ptr_reg + {{AW{1'b0}}, pop};
  end

  // Pointer registers
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else begin
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
    end
  end

  // Storage, no reset needed
  always_ff @(posedge mclk_i) begin
    if (push && !flush_i) begin
      mem[wr_ptr_reg[AW-1:0]] <= in_data_i;
    end
  end

endmodule

// >>> hdl/usb_rx_endpoint_status.sv
// Function
// - Data register read pops one payload byte
// - Strip PID and CRC16 before FIFO
// - Test mode lets bus write data register
// - Media fault sets status bit 7
// - Setup packet sets bit 6, read clears
// - Non-iso bit 5 shows last data PID
// - Iso bit 5 captures frame number LSB
// - Status read clears toggle bit
// - ACK sent sets bit 4, read clears
// - Bits 3:0 byte count, saturate at 15
// - Warn when free bytes below limit
// - Limit codes: off, under 5, under 17
// - Flush clears FIFO, deferred during reception
`timescale 1ns/1ps
module usb_rx_endpoint_status #(
  parameter int DEPTH = usb_rx_ep_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // Core bus
  input wire usb_rx_ep_pkg::core_req_type req_i,
  output logic [15:0] reg_rdata_o,
  output logic reg_ack_o,
  // Serial engine byte stream and endpoint context
  input wire usb_rx_ep_pkg::usb_rx_type rx_i,
  input wire logic iso_mode_i,
  input wire logic frame_number_lsb_i,
  input wire logic test_mode_i,
  // Link and event outputs
  output logic ack_send_o,
  output logic rx_warn_event_o
);

  localparam int CW = $clog2(DEPTH) + 1;

  if (DEPTH < usb_rx_ep_pkg::WARN_HIGH_FREE) begin : g_bad_depth
    $error("usb_rx_endpoint_status: DEPTH too small for warning limits");
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------

  // Reflected CRC16 update over one byte
  function automatic logic [15:0] crc16_byte(input logic [15:0] crc, input logic [7:0] b);
    logic [15:0] c;
    c = crc ^ {8'h00, b};
    for (int i = 0; i < usb_rx_ep_pkg::BYTE_W; i++) begin
      c = c[0] ? ((c >> 1) ^ usb_rx_ep_pkg::CRC_POLY_REFL) : (c >> 1);
    end
    return c;
  endfunction

  // Address match
  function automatic logic hit(input logic [31:0] a, input logic [31:0] b);
    return a == b;
  endfunction

  // ----------------------------------------------------------------
  // Bus decode and FIFO
  // ----------------------------------------------------------------
  logic rd_data;
  logic rd_stat;
  logic wr_data;
  logic wr_ctrl;
  logic fifo_in_valid;
  logic [7:0] fifo_in_data;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [7:0] fifo_out_data;
  logic [CW-1:0] fifo_count;
  logic flush_go;
  logic link_push;
  logic [7:0] link_byte;

  // Strobes per register
  always_comb begin
    rd_data = req_i.rd && hit(req_i.addr, usb_rx_ep_pkg::RX_FIFO_DATA_ADDR);
    rd_stat = req_i.rd && hit(req_i.addr, usb_rx_ep_pkg::RX_ENDPOINT_STATUS_ADDR);
    wr_data = req_i.wr && test_mode_i &&
              hit(req_i.addr, usb_rx_ep_pkg::RX_FIFO_DATA_ADDR);
    wr_ctrl = req_i.wr && hit(req_i.addr, usb_rx_ep_pkg::RX_ENDPOINT_CONTROL_ADDR);
  end

  // FIFO fill source: test write wins over the link
  always_comb begin
    fifo_in_valid = wr_data || link_push;
    fifo_in_data = wr_data ? req_i.wdata[7:0] : link_byte;
  end

  rx_byte_fifo #(
    .WIDTH(usb_rx_ep_pkg::BYTE_W),
    .DEPTH(DEPTH)
  ) u_fifo (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .flush_i(flush_go),
    .in_valid_i(fifo_in_valid),
    .in_data_i(fifo_in_data),
    .in_ready_o(fifo_in_ready),
    .out_valid_o(fifo_out_valid),
    .out_data_o(fifo_out_data),
    .out_ready_i(rd_data),
    .count_o(fifo_count)
  );

  // ----------------------------------------------------------------
  // Receive state machine
  // ----------------------------------------------------------------
  usb_rx_ep_pkg::rx_state_type state_reg;
  usb_rx_ep_pkg::rx_state_type state_next;
  logic [7:0] hold0_reg;
  logic [7:0] hold0_next;
  logic [7:0] hold1_reg;
  logic [7:0] hold1_next;
  logic [1:0] held_reg;
  logic [1:0] held_next;
  logic [15:0] crc_reg;
  logic [15:0] crc_next;
  logic bad_reg;
  logic bad_next;
  logic data1_reg;
  logic data1_next;
  logic setup_pkt_reg;
  logic setup_pkt_next;
  logic flush_pend_reg;
  logic flush_pend_next;
  logic done_ok;
  logic done_err;

  // Next state, payload delay line and packet verdict
  always_comb begin
    state_next = state_reg;
    hold0_next = hold0_reg;
    hold1_next = hold1_reg;
    held_next = held_reg;
    crc_next = crc_reg;
    bad_next = bad_reg;
    data1_next = data1_reg;
    setup_pkt_next = setup_pkt_reg;
    link_push = 1'b0;
    link_byte = hold0_reg;
    done_ok = 1'b0;
    done_err = 1'b0;
    flush_go = 1'b0;
    flush_pend_next = flush_pend_reg ||
                      (wr_ctrl && req_i.wdata[usb_rx_ep_pkg::CTRL_FLUSH_BIT]);
    if (rx_i.sop) begin
      state_next = usb_rx_ep_pkg::RX_PID;
      held_next = 2'h0;
      crc_next = usb_rx_ep_pkg::CRC_INIT;
      bad_next = 1'b0;
      setup_pkt_next = rx_i.setup;
    end else begin
      unique case (state_reg)
        usb_rx_ep_pkg::RX_IDLE: begin
          if (flush_pend_reg) begin
            flush_go = 1'b1;
            flush_pend_next = 1'b0;
          end
        end
        usb_rx_ep_pkg::RX_PID: begin
          if (rx_i.valid) begin
            data1_next = rx_i.data[usb_rx_ep_pkg::PID_DATA1_BIT];
            state_next = usb_rx_ep_pkg::RX_DATA;
          end
          if (rx_i.eop) begin
            state_next = usb_rx_ep_pkg::RX_IDLE;
          end
        end
        usb_rx_ep_pkg::RX_DATA: begin
          if (rx_i.valid) begin
            crc_next = crc16_byte(crc_reg, rx_i.data);
            // Last two bytes stay held so the CRC never reaches the FIFO
            if (held_reg == usb_rx_ep_pkg::CRC_BYTES) begin
              link_push = !wr_data;
              if (!fifo_in_ready || wr_data) begin
                bad_next = 1'b1;
              end
              hold0_next = hold1_reg;
              hold1_next = rx_i.data;
            end else begin
              if (held_reg == 2'h0) begin
                hold0_next = rx_i.data;
              end else begin
                hold1_next = rx_i.data;
              end
              held_next = held_reg + 2'h1;
            end
          end
          if (rx_i.stuff_err) begin
            bad_next = 1'b1;
          end
          if (rx_i.eop) begin
            state_next = usb_rx_ep_pkg::RX_IDLE;
            if (bad_next || rx_i.stuff_err ||
                held_next != usb_rx_ep_pkg::CRC_BYTES ||
                crc_next != usb_rx_ep_pkg::CRC_RESIDUAL) begin
              done_err = 1'b1;
            end else if (!bad_next) begin
              done_ok = 1'b1;
            end
          end
        end
        default: state_next = usb_rx_ep_pkg::RX_IDLE;
      endcase
    end
  end

  // Receive state registers
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= usb_rx_ep_pkg::RX_IDLE;
      hold0_reg <= 8'h00;
      hold1_reg <= 8'h00;
      held_reg <= 2'h0;
      crc_reg <= usb_rx_ep_pkg::CRC_INIT;
      bad_reg <= 1'b0;
      data1_reg <= 1'b0;
      setup_pkt_reg <= 1'b0;
      flush_pend_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      hold0_reg <= hold0_next;
      hold1_reg <= hold1_next;
      held_reg <= held_next;
      crc_reg <= crc_next;
      bad_reg <= bad_next;
      data1_reg <= data1_next;
      setup_pkt_reg <= setup_pkt_next;
      flush_pend_reg <= flush_pend_next;
    end
  end

  // ----------------------------------------------------------------
  // Status, control and bus answer
  // ----------------------------------------------------------------
  logic err_reg;
  logic err_next;
  logic setup_reg;
  logic setup_next;
  logic toggle_reg;
  logic toggle_next;
  logic last_reg;
  logic last_next;
  logic [1:0] warn_lim_reg;
  logic [1:0] warn_lim_next;
  logic [15:0] rdata_next;
  logic ack_send_next;
  logic warn_next;
  logic [3:0] count_sat;
  logic [CW-1:0] free_bytes;

  // Event bits: hardware set wins over a read clear
  always_comb begin
    count_sat = (fifo_count > CW'(usb_rx_ep_pkg::COUNT_SAT)) ?
                usb_rx_ep_pkg::COUNT_SAT : fifo_count[3:0];
    free_bytes = CW'(DEPTH) - fifo_count;
    err_next = flush_go ? 1'b0 : err_reg;
    setup_next = rd_stat ? 1'b0 : setup_reg;
    toggle_next = rd_stat ? 1'b0 : toggle_reg;
    last_next = rd_stat ? 1'b0 : last_reg;
    ack_send_next = 1'b0;
    if (done_err) begin
      err_next = 1'b1;
    end
    if (done_ok) begin
      setup_next = setup_reg || setup_pkt_reg || (rd_stat ? 1'b0 : setup_reg);
      if (!setup_pkt_reg && rd_stat) begin
        setup_next = 1'b0;
      end
      if (setup_pkt_reg) begin
        setup_next = 1'b1;
      end
      toggle_next = iso_mode_i ? frame_number_lsb_i : data1_reg;
      if (!iso_mode_i) begin
        ack_send_next = 1'b1;
        last_next = 1'b1;
      end
    end
    warn_lim_next = warn_lim_reg;
    if (wr_ctrl) begin
      warn_lim_next = req_i.wdata[usb_rx_ep_pkg::CTRL_WARN_MSB:usb_rx_ep_pkg::CTRL_WARN_LSB];
    end
    // Code 11 falls into the default and never warns
    unique case (warn_lim_reg)
      usb_rx_ep_pkg::WARN_LOW: warn_next = free_bytes < CW'(usb_rx_ep_pkg::WARN_LOW_FREE);
      usb_rx_ep_pkg::WARN_HIGH:
        warn_next = free_bytes < CW'(usb_rx_ep_pkg::WARN_HIGH_FREE);
      default: warn_next = 1'b0;
    endcase
    rdata_next = usb_rx_ep_pkg::REG_RESET;
    if (rd_data) begin
      rdata_next[7:0] = fifo_out_valid ? fifo_out_data : 8'h00;
    end else if (rd_stat) begin
      rdata_next[usb_rx_ep_pkg::STAT_ERR_BIT] = err_reg;
      rdata_next[usb_rx_ep_pkg::STAT_SETUP_BIT] = setup_reg;
      rdata_next[usb_rx_ep_pkg::STAT_TOGGLE_BIT] = toggle_reg;
      rdata_next[usb_rx_ep_pkg::STAT_LAST_BIT] = last_reg;
      rdata_next[usb_rx_ep_pkg::STAT_COUNT_MSB:0] = count_sat;
    end else if (req_i.rd && hit(req_i.addr, usb_rx_ep_pkg::RX_ENDPOINT_CONTROL_ADDR)) begin
      rdata_next[usb_rx_ep_pkg::CTRL_WARN_MSB:usb_rx_ep_pkg::CTRL_WARN_LSB] = warn_lim_reg;
      rdata_next[usb_rx_ep_pkg::CTRL_FLUSH_BIT] = flush_pend_reg;
    end
  end

  // Status and output registers
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      err_reg <= 1'b0;
      setup_reg <= 1'b0;
      toggle_reg <= 1'b0;
      last_reg <= 1'b0;
      warn_lim_reg <= usb_rx_ep_pkg::WARN_OFF;
      reg_rdata_o <= usb_rx_ep_pkg::REG_RESET;
      reg_ack_o <= 1'b0;
      ack_send_o <= 1'b0;
      rx_warn_event_o <= 1'b0;
    end else begin
      err_reg <= err_next;
      setup_reg <= setup_next;
      toggle_reg <= toggle_next;
      last_reg <= last_next;
      warn_lim_reg <= warn_lim_next;
      reg_rdata_o <= rdata_next;
      reg_ack_o <= req_i.rd || req_i.wr;
      ack_send_o <= ack_send_next;
      rx_warn_event_o <= warn_next;
    end
  end

endmodule

// >>> hdl/usb_rx_ep_pkg.sv
package usb_rx_ep_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [31:0] RX_FIFO_DATA_ADDR = 32'h5000186a;
  localparam logic [31:0] RX_ENDPOINT_STATUS_ADDR = 32'h5000186c;
  localparam logic [31:0] RX_ENDPOINT_CONTROL_ADDR = 32'h5000186e;
  localparam logic [15:0] REG_RESET = 16'h0000;

  // Status field positions
  localparam int STAT_ERR_BIT = 7;
  localparam int STAT_SETUP_BIT = 6;
  localparam int STAT_TOGGLE_BIT = 5;
  localparam int STAT_LAST_BIT = 4;
  localparam int STAT_COUNT_MSB = 3;
  localparam logic [3:0] COUNT_SAT = 4'hf;

  // Control field positions
  localparam int CTRL_WARN_MSB = 6;
  localparam int CTRL_WARN_LSB = 5;
  localparam int CTRL_FLUSH_BIT = 3;

  // Warning limit codes and free-byte thresholds
  localparam logic [1:0] WARN_OFF = 2'h0;
  localparam logic [1:0] WARN_LOW = 2'h1;
  localparam logic [1:0] WARN_HIGH = 2'h2;
  localparam int WARN_LOW_FREE = 5;
  localparam int WARN_HIGH_FREE = 17;

  // FIFO and packet constants
  localparam int FIFO_DEPTH = 32;
  localparam int BYTE_W = 8;
  localparam int PID_DATA1_BIT = 3;
  localparam logic [15:0] CRC_INIT = 16'hffff;
  localparam logic [15:0] CRC_POLY_REFL = 16'ha001;
  localparam logic [15:0] CRC_RESIDUAL = 16'hb001;
  localparam logic [1:0] CRC_BYTES = 2'h2;

  // Receive state machine
  typedef enum logic [1:0] {RX_IDLE, RX_PID, RX_DATA} rx_state_type;

  // Decoded byte stream from the serial engine
  typedef struct packed {
    logic sop;
    logic eop;
    logic valid;
    logic [7:0] data;
    logic stuff_err;
    logic setup;
  } usb_rx_type;

  // Core bus request
  typedef struct packed {
    logic [31:0] addr;
    logic rd;
    logic wr;
    logic [15:0] wdata;
  } core_req_type;

endpackage

// >>> tb/usb_host_model.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Host side byte stream
// ------------------------------------------------------------
module usb_host_model (
  // Clock
  input wire logic mclk_i,
  // Byte stream to the endpoint
  output usb_rx_ep_pkg::usb_rx_type rx_o
);
  // Idle stream at time zero
  initial rx_o = '0;
  // One packet: start, PID, payload, checksum, end
  task automatic send(input logic [7:0] pid, input logic [7:0] pl[$], input logic setup,
                      input int fault);
    logic [15:0] crc;
    crc = usb_rx_ep_pkg::CRC_INIT;
    foreach (pl[i]) begin
      crc = crc ^ {8'h00, pl[i]};
      repeat (8) crc = crc[0] ? (crc >> 1) ^ usb_rx_ep_pkg::CRC_POLY_REFL : crc >> 1;
    end
    crc = ~crc ^ {15'h0000, fault == 1};
    pl.push_back(crc[7:0]);
    pl.push_back(crc[15:8]);
    @(posedge mclk_i) #1;
    rx_o = '0;
    rx_o.sop = 1'b1;
    rx_o.setup = setup;
    @(posedge mclk_i) #1;
    rx_o.sop = 1'b0;
    rx_o.valid = 1'b1;
    rx_o.data = pid;
    foreach (pl[i]) begin
      @(posedge mclk_i) #1;
      rx_o.data = pl[i];
      rx_o.stuff_err = (fault == 2) && (i == 0);
    end
    @(posedge mclk_i) #1;
    rx_o.valid = 1'b0;
    rx_o.stuff_err = 1'b0;
    rx_o.eop = 1'b1;
    rx_o.data = ~rx_o.data;
    @(posedge mclk_i) #1;
    rx_o.eop = 1'b0;
  endtask
endmodule

// >>> tb/usb_rx_endpoint_status_monitor.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Endpoint port checker
// ------------------------------------------------------------
module usb_rx_endpoint_status_monitor #(
  parameter int DEPTH = 32
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // Core bus
  input wire usb_rx_ep_pkg::core_req_type req_i,
  input wire logic [15:0] reg_rdata_o,
  input wire logic reg_ack_o,
  // Byte stream and context
  input wire usb_rx_ep_pkg::usb_rx_type rx_i,
  input wire logic iso_mode_i,
  input wire logic frame_number_lsb_i,
  input wire logic test_mode_i,
  // Events
  input wire logic ack_send_o,
  input wire logic rx_warn_event_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  logic strobe;
  logic rd_stat;
  logic rd_data;
  logic ctrl_sel;
  logic rd_unmapped;
  logic [1:0] code_reg;
  logic [1:0] code_next;
  // Decoded bus requests
  assign strobe = req_i.rd | req_i.wr;
  assign rd_stat = req_i.rd && (req_i.addr == usb_rx_ep_pkg::RX_ENDPOINT_STATUS_ADDR);
  assign rd_data = req_i.rd && (req_i.addr == usb_rx_ep_pkg::RX_FIFO_DATA_ADDR);
  assign ctrl_sel = req_i.addr == usb_rx_ep_pkg::RX_ENDPOINT_CONTROL_ADDR;
  assign rd_unmapped = req_i.rd && !rd_stat && !rd_data && !ctrl_sel;
  // Shadow of the warning limit field
  always_comb begin
    code_next = code_reg;
    if (req_i.wr && ctrl_sel) begin
      code_next = req_i.wdata[6:5];
    end
  end
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      code_reg <= 2'h0;
    end else begin
      code_reg <= code_next;
    end
  end
  // Status read, quiet gap, status read
  sequence quiet_stat_read;
    rd_stat && !rx_i.eop;
  endsequence
  sequence spaced_stat_reads;
    quiet_stat_read ##1 !rx_i.eop ##1 rd_stat;
  endsequence
  chk_ack_after_strobe: assert property (strobe |=> reg_ack_o)
    else $error("no acknowledge after bus strobe");
  chk_ack_has_cause: assert property (reg_ack_o |-> $past(strobe))
    else $error("acknowledge without strobe");
  chk_rdata_idle_zero: assert property (!reg_ack_o |-> reg_rdata_o == 16'h0000)
    else $error("read data not zero outside answer");
  chk_data_upper_zero: assert property (rd_data |=> reg_rdata_o[15:8] == 8'h00)
    else $error("data read upper byte not zero");
  chk_unmapped_zero: assert property (rd_unmapped |=> reg_rdata_o == 16'h0000)
    else $error("unmapped read not zero");
  chk_events_cleared: assert property
    (spaced_stat_reads |=> reg_rdata_o[6:4] == 3'h0)
    else $error("status events not cleared by read");
  chk_iso_no_ack: assert property (rx_i.eop && iso_mode_i |=> !ack_send_o)
    else $error("handshake sent on isochronous endpoint");
  chk_ack_from_eop: assert property (ack_send_o |-> $past(rx_i.eop) && !$past(iso_mode_i))
    else $error("handshake without packet end");
  chk_ack_one_pulse: assert property (ack_send_o |=> !ack_send_o)
    else $error("handshake longer than one cycle");
  chk_warn_code_off: assert property ((code_reg == 2'h0 || code_reg == 2'h3) [*3]
    |-> !rx_warn_event_o)
    else $error("warning raised while limit disabled");
endmodule
bind usb_rx_endpoint_status usb_rx_endpoint_status_monitor #(.DEPTH(DEPTH)) u_monitor (
  .mclk_i(mclk_i), .rst_n_i(rst_n_i), .req_i(req_i), .reg_rdata_o(reg_rdata_o),
  .reg_ack_o(reg_ack_o), .rx_i(rx_i), .iso_mode_i(iso_mode_i),
  .frame_number_lsb_i(frame_number_lsb_i), .test_mode_i(test_mode_i),
  .ack_send_o(ack_send_o), .rx_warn_event_o(rx_warn_event_o));

// >>> tb/usb_rx_endpoint_status_test.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) \
  begin \
    n_checks++; \
    if ((g) !== (e)) begin \
      fail_count++; \
      $display("MISMATCH %s exp %h got %h", nm, e, g); \
    end \
  end
// ------------------------------------------------------------
// Endpoint status bench
// ------------------------------------------------------------
module usb_rx_endpoint_status_test;
  localparam logic [31:0] a_data = usb_rx_ep_pkg::RX_FIFO_DATA_ADDR;
  localparam logic [31:0] a_stat = usb_rx_ep_pkg::RX_ENDPOINT_STATUS_ADDR;
  localparam logic [31:0] a_ctrl = usb_rx_ep_pkg::RX_ENDPOINT_CONTROL_ADDR;
  logic mclk_i = 1'b0;
  logic rst_n_i;
  usb_rx_ep_pkg::core_req_type req_i;
  usb_rx_ep_pkg::usb_rx_type rx_i;
  logic [15:0] reg_rdata_o;
  logic reg_ack_o;
  logic iso_mode_i;
  logic frame_number_lsb_i;
  logic test_mode_i;
  logic ack_send_o;
  logic rx_warn_event_o;
  logic rd_d = 1'b0;
  logic [31:0] seed;
  logic [31:0] note;
  logic [31:0] exp_q[$];
  logic [7:0] pl[$];
  logic [7:0] b;
  logic [15:0] st_exp[3] = '{16'h0033, 16'h0053, 16'h0023};
  int fail_count = 0;
  int n_checks = 0;
  // Clock
  always #5 mclk_i = ~mclk_i;
  usb_rx_endpoint_status u_usb_rx_endpoint_status (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
    .req_i(req_i), .reg_rdata_o(reg_rdata_o), .reg_ack_o(reg_ack_o), .rx_i(rx_i),
    .iso_mode_i(iso_mode_i), .frame_number_lsb_i(frame_number_lsb_i),
    .test_mode_i(test_mode_i), .ack_send_o(ack_send_o), .rx_warn_event_o(rx_warn_event_o));
  usb_host_model u_usb_host_model (.mclk_i(mclk_i), .rx_o(rx_i));
  // Random bytes
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // One bus access, strobe for one cycle
  task automatic bus(input logic [31:0] a, input logic rd, input logic [15:0] wd);
    req_i = '{addr: a, rd: rd, wr: !rd, wdata: wd};
    @(posedge mclk_i) #1;
    req_i = '0;
    @(posedge mclk_i) #1;
  endtask
  // Read with expected value noted for the watcher
  task automatic rd(input logic [31:0] a, input logic [15:0] e, input logic [15:0] m = 16'hffff);
    exp_q.push_back({m, e});
    bus(a, 1'b1, 16'h0000);
  endtask
  task automatic report_and_stop;
    if (fail_count == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Watcher: oldest note against each read answer
  always @(posedge mclk_i) begin
    if (rd_d) begin
      `CHK("reg_ack_o", 1'b1, reg_ack_o)
      note = exp_q.pop_front();
      `CHK("reg_rdata_o", note[15:0], reg_rdata_o & note[31:16])
    end
    rd_d <= req_i.rd;
  end
  // Watchdog
  initial begin
    #500000;
    fail_count++;
    report_and_stop();
  end
  // Main sequence
  initial begin
    seed = 32'h6b11;
    req_i = '0;
    iso_mode_i = 1'b0;
    frame_number_lsb_i = 1'b1;
    test_mode_i = 1'b0;
    rst_n_i = 1'b0;
    repeat (12) @(posedge mclk_i);
    #1 rst_n_i = 1'b1;
    @(posedge mclk_i) #1;
    rd(a_data, 16'h0000);
    rd(a_stat, 16'h0000);
    rd(a_ctrl, 16'h0000);
    rd(32'h50001870, 16'h0000);
    // DATA1, SETUP with DATA0, isochronous with PID bit against frame bit
    for (int k = 0; k < 3; k++) begin
      pl = {};
      repeat (3) pl.push_back(8'(rnd()));
      iso_mode_i = (k == 2);
      frame_number_lsb_i = 1'(rnd());
      st_exp[2][5] = frame_number_lsb_i;
      u_usb_host_model.send((k == 0 || (k == 2 && !frame_number_lsb_i)) ? 8'h4b : 8'hc3,
                            pl, k == 1, 0);
      `CHK("ack_send_o", 1'(k != 2), ack_send_o)
      rd(a_stat, st_exp[k]);
      rd(a_stat, 16'h0003);
      foreach (pl[i]) rd(a_data, {8'h00, pl[i]});
    end
    iso_mode_i = 1'b0;
    // Bad checksum, then stuffing fault; firmware flushes
    for (int f = 1; f < 3; f++) begin
      u_usb_host_model.send(8'h4b, pl, 1'b0, f);
      `CHK("ack_send_o", 1'b0, ack_send_o)
      rd(a_stat, 16'h0080, 16'hfff0);
      bus(a_ctrl, 1'b0, 16'h0008);
      rd(a_stat, 16'h0000);
    end
    // Flush written in mid-packet waits for the end
    repeat (3) pl.push_back(8'(rnd()));
    fork
      u_usb_host_model.send(8'hc3, pl, 1'b0, 0);
      begin
        repeat (4) @(posedge mclk_i);
        #1 bus(a_ctrl, 1'b0, 16'h0008);
        rd(a_ctrl, 16'h0008);
      end
    join
    `CHK("ack_send_o", 1'b1, ack_send_o)
    // Deferred flush runs in the first idle cycle after the end
    @(posedge mclk_i) #1;
    rd(a_stat, 16'h0000, 16'h000f);
    // Count saturation and warning limit codes
    pl = {};
    repeat (20) pl.push_back(8'(rnd()));
    u_usb_host_model.send(8'hc3, pl, 1'b0, 0);
    rd(a_stat, 16'h001f);
    for (int c = 0; c < 4; c++) begin
      bus(a_ctrl, 1'b0, 16'(c << 5));
      @(posedge mclk_i) #1;
      `CHK("rx_warn_event_o", 1'(c == 2), rx_warn_event_o)
    end
    // Test mode fills the buffer until it refuses
    test_mode_i = 1'b1;
    bus(a_ctrl, 1'b0, 16'h0020);
    for (int i = 0; i < 13; i++) begin
      b = 8'(rnd());
      if (i < 12) pl.push_back(b);
      bus(a_data, 1'b0, {8'h00, b});
      @(posedge mclk_i) #1;
      `CHK("rx_warn_event_o", 1'(i >= 7), rx_warn_event_o)
    end
    test_mode_i = 1'b0;
    rd(a_stat, 16'h000f);
    foreach (pl[i]) rd(a_data, {8'h00, pl[i]});
    rd(a_data, 16'h0000);
    `CHK("rx_warn_event_o", 1'b0, rx_warn_event_o)
    bus(a_data, 1'b0, 16'h00aa);
    rd(a_stat, 16'h0000);
    report_and_stop();
  end
endmodule
